// File: lpm_consts.svh
// timing counts, sizes and wake bit positions for the low-power mode controller
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_CLK_MHZ 100
`define LPM_RESET_HOLD_NS 200
`define LPM_RESET_HOLD_CYC ((`LPM_RESET_HOLD_NS * `LPM_CLK_MHZ + 999) / 1000)
`define LPM_BKP_COUNT 10
`define LPM_BKP_WIDTH 16
`define LPM_EXT_LINES 16
`define LPM_CNT_W 8
// bit positions inside the packed wake word
`define LPM_WAKE_PVD_BIT 4
`define LPM_WAKE_ALARM_BIT 3
`define LPM_WAKE_WDG_BIT 1
`endif

// File: lpm_pkg.sv
// types for the low-power mode controller
package lpm_pkg;
  // regulator state, exactly one at a time
  typedef enum logic [1:0] {
    REG_MAIN = 2'b00,
    REG_LOW_POWER = 2'b01,
    REG_OFF = 2'b10
  } reg_state_t;
  // power modes
  typedef enum logic [2:0] {
    M_RESET = 3'b000,
    M_RUN = 3'b001,
    M_SLEEP = 3'b010,
    M_STOP = 3'b011,
    M_STANDBY = 3'b100
  } mode_t;
  // mode request from the cpu
  typedef enum logic [1:0] {
    REQ_NONE = 2'b00,
    REQ_SLEEP = 2'b01,
    REQ_STOP = 2'b10,
    REQ_STANDBY = 2'b11
  } req_t;
  // clock and oscillator enables
  typedef struct packed {
    logic cpu_clk;
    logic periph_clk;
    logic pll;
    logic internal_high_speed_rc;
    logic external_high_speed_osc;
    logic low_speed_clk;
  } clk_en_t;
  // wake sources as they arrive at the port, before synchronisation
  typedef struct packed {
    logic [15:0] ext_lines;
    logic supply_voltage_detector;
    logic rtc_alarm;
    logic wakeup_pin;
    logic watchdog_reset;
    logic reset_pin_n;
  } wake_t;
endpackage : lpm_pkg

// File: low_power_mode_controller.sv
// low-power mode controller: run, sleep, stop and standby sequencing
`timescale 1ns/1ns
`include "lpm_consts.svh"
module low_power_mode_controller
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // cpu request side
  input wire req_t MODE_REQ,
  input wire logic STOP_LOW_POWER,
  input wire logic ANY_EVENT,
  output logic CPU_RELEASE,
  output logic STANDBY_FLAG,
  // wake inputs from pins and always-on blocks
  input wire wake_t WAKE_IN,
  // backup register access
  input wire logic BKP_WE,
  input wire logic [3:0] BKP_ADDR,
  input wire logic [15:0] BKP_WDATA,
  output logic [15:0] BKP_RDATA,
  // power and clock controls
  output reg_state_t REGULATOR,
  output logic REGULATOR_EN,
  output logic CORE_RESET_N,
  output clk_en_t CLK_EN,
  output mode_t MODE
);
  localparam int WW = $bits(wake_t);
  localparam int HOLD = `LPM_RESET_HOLD_CYC;

  // whole state of the block apart from the backup registers
  typedef struct packed {
    mode_t mode;
    logic stop_lp; // regulator choice latched at stop entry
    logic [`LPM_CNT_W-1:0] cnt; // reset sequence counter
    logic [WW-1:0] s1, s2, s3; // three-stage pin synchroniser
    logic lost; // core state was discarded
    logic pin_lvl; // last agreed wakeup pin level, for edge detection
  } state_t;

  state_t st, next_st;
  // backup domain kept apart: never cleared by the core reset
  logic [`LPM_BKP_WIDTH-1:0] bkp [`LPM_BKP_COUNT];

  // a change counts only when stages two and three agree
  function automatic logic agreed(input logic [WW-1:0] a, b, input int i);
    agreed = a[i] & b[i];
  endfunction : agreed

  logic [15:0] ext_ok;
  logic pvd_ok, alarm_ok, pin_ok, pin_low, pin_rise, wdg_ok, rstp_low;

  // qualified wake levels
  always_comb begin
    wake_t a, b;
    a = wake_t'(st.s2);
    b = wake_t'(st.s3);
    ext_ok = a.ext_lines & b.ext_lines;
    pvd_ok = agreed(st.s2, st.s3, `LPM_WAKE_PVD_BIT);
    alarm_ok = agreed(st.s2, st.s3, `LPM_WAKE_ALARM_BIT);
    wdg_ok = agreed(st.s2, st.s3, `LPM_WAKE_WDG_BIT);
    rstp_low = ~a.reset_pin_n & ~b.reset_pin_n;
    pin_ok = a.wakeup_pin & b.wakeup_pin; // stages agree high
    pin_low = ~a.wakeup_pin & ~b.wakeup_pin; // stages agree low
    // rising edge only once the stages agree, so a glitch cannot wake
    pin_rise = pin_ok & ~st.pin_lvl;
  end

  // next state
  always_comb begin
    next_st = st;
    next_st.s1 = WAKE_IN;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // remember the last level both stages agreed on
    if (pin_ok) begin
      next_st.pin_lvl = 1'b1;
    end else if (pin_low) begin
      next_st.pin_lvl = 1'b0;
    end
    unique case (st.mode)
      M_RESET: begin
        // hold the core in reset with the regulator up
        if (st.cnt == `LPM_CNT_W'(HOLD - 1)) begin
          next_st.mode = M_RUN;
          next_st.cnt = '0;
        end else begin
          next_st.cnt = st.cnt + `LPM_CNT_W'(1);
        end
      end
      M_RUN: begin
        next_st.lost = 1'b0;
        unique case (MODE_REQ)
          REQ_SLEEP: next_st.mode = M_SLEEP;
          REQ_STOP: begin
            next_st.mode = M_STOP;
            next_st.stop_lp = STOP_LOW_POWER;
          end
          REQ_STANDBY: next_st.mode = M_STANDBY;
          REQ_NONE: next_st.mode = M_RUN;
        endcase
      end
      M_SLEEP: begin
        // any interrupt or event resumes the cpu
        if (ANY_EVENT) next_st.mode = M_RUN;
      end
      M_STOP: begin
        // any external event line ends stop, state kept
        if (|ext_ok || pvd_ok || alarm_ok) next_st.mode = M_RUN;
      end
      M_STANDBY: begin
        next_st.lost = 1'b1;
        // four causes; exit through a full reset sequence
        if (rstp_low || wdg_ok || pin_rise || alarm_ok) begin
          next_st.mode = M_RESET;
          next_st.cnt = '0;
        end
      end
      default: next_st.mode = M_RESET;
    endcase
  end

  // register the state; reset restarts the core sequence
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // backup registers, written only in run mode, unaffected by core reset
  always_ff @(posedge CLK) begin
    if (BKP_WE && st.mode == M_RUN && BKP_ADDR < 4'(`LPM_BKP_COUNT)) begin
      bkp[BKP_ADDR] <= BKP_WDATA;
    end
  end
  assign BKP_RDATA = (BKP_ADDR < 4'(`LPM_BKP_COUNT)) ? bkp[BKP_ADDR] : 16'h0000;

  // regulator state from mode
  always_comb begin
    unique case (st.mode)
      M_STANDBY: REGULATOR = REG_OFF;
      M_STOP: REGULATOR = st.stop_lp ? REG_LOW_POWER : REG_MAIN;
      default: REGULATOR = REG_MAIN;
    endcase
  end
  assign REGULATOR_EN = (st.mode != M_STANDBY);

  // clock gating per mode
  always_comb begin
    logic core_on;
    core_on = (st.mode == M_RUN) || (st.mode == M_SLEEP) || (st.mode == M_RESET);
    CLK_EN.cpu_clk = (st.mode == M_RUN);
    CLK_EN.periph_clk = core_on;
    CLK_EN.pll = core_on;
    CLK_EN.internal_high_speed_rc = core_on;
    CLK_EN.external_high_speed_osc = core_on;
    CLK_EN.low_speed_clk = 1'b1;
  end

  assign CORE_RESET_N = (st.mode != M_RESET) && (st.mode != M_STANDBY);
  assign CPU_RELEASE = (st.mode == M_RUN);
  assign STANDBY_FLAG = st.lost;
  assign MODE = st.mode;

  // checks
  a_reg_onehot: assert property (@(posedge CLK) disable iff (!RST_N)
    REGULATOR inside {REG_MAIN, REG_LOW_POWER, REG_OFF})
    else $error("regulator state illegal");
  a_run_main: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_RUN |-> REGULATOR == REG_MAIN)
    else $error("run without main regulator");
  a_stop_lp: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(MODE == M_STOP) && $past(STOP_LOW_POWER) |-> REGULATOR == REG_LOW_POWER)
    else $error("stop low power not applied");
  a_standby_off: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_STANDBY |-> !REGULATOR_EN && REGULATOR == REG_OFF && !CORE_RESET_N)
    else $error("standby regulator not off");
  a_reg_enable: assert property (@(posedge CLK) disable iff (!RST_N)
    !REGULATOR_EN |-> MODE == M_STANDBY)
    else $error("regulator off outside standby");
  a_sleep_clocks: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_SLEEP |-> !CLK_EN.cpu_clk && CLK_EN.periph_clk)
    else $error("sleep clocks wrong");
  a_sleep_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_SLEEP && ANY_EVENT |=> MODE == M_RUN)
    else $error("sleep did not wake");
  a_stop_clocks: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE inside {M_STOP, M_STANDBY} |-> !CLK_EN.pll && !CLK_EN.internal_high_speed_rc
      && !CLK_EN.external_high_speed_osc && CLK_EN.low_speed_clk)
    else $error("stop clocks wrong");
  a_stop_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_STOP && WAKE_IN.rtc_alarm [*4] |-> ##[0:1] MODE == M_RUN)
    else $error("stop did not wake");
  a_standby_wake: assert property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_STANDBY && WAKE_IN.watchdog_reset [*4] |-> ##[0:1] MODE == M_RESET)
    else $error("standby did not wake");
  a_reset_seq: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(MODE == M_STANDBY) |-> !CPU_RELEASE [*8] ##[0:30] CPU_RELEASE)
    else $error("cpu released early");

  c_sleep: cover property (@(posedge CLK) disable iff (!RST_N) MODE == M_SLEEP ##1 MODE == M_RUN);
  c_stop: cover property (@(posedge CLK) disable iff (!RST_N) MODE == M_STOP ##1 MODE == M_RUN);
  c_standby: cover property (@(posedge CLK) disable iff (!RST_N)
    MODE == M_STANDBY ##1 MODE == M_RESET);
endmodule : low_power_mode_controller

// File: cpu_model.sv
// cpu core model that raises mode requests while released
`timescale 1ns/1ns
module cpu_model
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bench command and core status
  input wire req_t WANT,
  input wire logic WANT_LP,
  input wire logic CPU_RELEASE,
  // request lines toward the controller
  output req_t MODE_REQ,
  output logic STOP_LOW_POWER
);
  // a halted core cannot run its entry instruction, so the request drops
  always_ff @(posedge CLK) begin
    if (!RST_N || !CPU_RELEASE) begin
      MODE_REQ <= REQ_NONE;
    end else begin
      MODE_REQ <= WANT;
    end
    // regulator choice travels with the request
    STOP_LOW_POWER <= WANT_LP;
  end
endmodule : cpu_model

// File: testbench.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/1ns
module testbench;
  import lpm_pkg::*;
  logic clk, rst_n, any_event, bkp_we, want_lp, stop_lp, cpu_release;
  logic standby_flag, regulator_en, core_reset_n;
  req_t mode_req, want;
  wake_t wake_in;
  logic [3:0] bkp_addr;
  logic [15:0] bkp_wdata, bkp_rdata;
  logic [15:0] shadow [10]; // expected backup contents
  reg_state_t regulator;
  clk_en_t clk_en;
  mode_t mode;
  int fails, checked, i, k, seed;
  cpu_model cpu (.CLK(clk), .RST_N(rst_n), .WANT(want), .WANT_LP(want_lp),
    .CPU_RELEASE(cpu_release), .MODE_REQ(mode_req), .STOP_LOW_POWER(stop_lp));
  low_power_mode_controller dut (.CLK(clk), .RST_N(rst_n), .MODE_REQ(mode_req),
    .STOP_LOW_POWER(stop_lp), .ANY_EVENT(any_event), .CPU_RELEASE(cpu_release),
    .STANDBY_FLAG(standby_flag), .WAKE_IN(wake_in), .BKP_WE(bkp_we),
    .BKP_ADDR(bkp_addr), .BKP_WDATA(bkp_wdata), .BKP_RDATA(bkp_rdata),
    .REGULATOR(regulator), .REGULATOR_EN(regulator_en),
    .CORE_RESET_N(core_reset_n), .CLK_EN(clk_en), .MODE(mode));
  // 100 mhz clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // clock enables the rules ask for in each mode
  function automatic logic [5:0] exp_clk(mode_t m);
    case (m)
      M_RUN: exp_clk = 6'h3f;
      M_SLEEP: exp_clk = 6'h1f;
      default: exp_clk = 6'h01;
    endcase
  endfunction : exp_clk
  // inputs always move 1 ns after the edge
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // bounded wait: sync stages plus reset sequence fit well inside 60
  task automatic wait_mode(mode_t m);
    for (int j = 0; j < 60 && mode !== m; j++) cyc(1);
    chk("mode", mode, m);
  endtask : wait_mode
  task automatic enter(req_t r, logic lp);
    want = r;
    want_lp = lp;
    wait_mode(mode_t'({1'b0, r} + 3'd1));
    want = REQ_NONE;
  endtask : enter
  // read back every slot, the unmapped one reads zero
  task automatic check_bkp();
    for (int j = 0; j < 11; j++) begin
      bkp_addr = j[3:0];
      cyc(1);
      chk("backup", bkp_rdata, j < 10 ? shadow[j] : 16'h0000);
    end
  endtask : check_bkp
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // watchdog, far beyond the several hundred cycles expected
  initial begin
    #300000;
    fails++;
    conclude();
  end
  initial begin
    seed = $urandom(13788);
    rst_n = 0;
    want = REQ_NONE;
    want_lp = 0;
    any_event = 0;
    bkp_we = 0;
    bkp_addr = 0;
    bkp_wdata = 0;
    wake_in = '0;
    wake_in.reset_pin_n = 1;
    cyc(5);
    chk("core_reset_n", core_reset_n, 0);
    chk("regulator_en", regulator_en, 1);
    rst_n = 1;
    cyc(10);
    chk("mode", mode, M_RESET);
    wait_mode(M_RUN);
    chk("regulator", regulator, REG_MAIN);
    chk("clk_en", clk_en, exp_clk(M_RUN));
    // fill the backup slots with random data, one past the end too
    for (i = 0; i < 11; i++) begin
      bkp_addr = i[3:0];
      bkp_wdata = 16'($urandom);
      bkp_we = 1;
      if (i < 10) shadow[i] = bkp_wdata;
      cyc(1);
    end
    bkp_we = 0;
    check_bkp();
    // sleep: only the cpu clock halts
    enter(REQ_SLEEP, 0);
    chk("clk_en", clk_en, exp_clk(M_SLEEP));
    cyc($urandom_range(1, 8));
    any_event = 1;
    cyc(1);
    any_event = 0;
    chk("mode", mode, M_RUN);
    // stop: each external line, the detector and the alarm wake it
    for (k = 0; k < 18; k++) begin
      enter(REQ_STOP, k[0]);
      chk("regulator", regulator, k[0] ? REG_LOW_POWER : REG_MAIN);
      chk("clk_en", clk_en, exp_clk(M_STOP));
      cyc($urandom_range(1, 8));
      wake_in[20-k] = 1;
      wait_mode(M_RUN);
      wake_in[20-k] = 0;
      check_bkp();
    end
    // reset in mid-stop: back through the core sequence, backup kept
    enter(REQ_STOP, 1);
    rst_n = 0;
    cyc(2);
    chk("mode", mode, M_RESET);
    chk("regulator_en", regulator_en, 1);
    chk("regulator", regulator, REG_MAIN);
    rst_n = 1;
    cyc(2);
    chk("cpu_release", cpu_release, 0);
    wait_mode(M_RUN);
    check_bkp();
    // standby: four causes, an external line must not end it
    for (k = 0; k < 4; k++) begin
      enter(REQ_STANDBY, 0);
      chk("regulator", regulator, REG_OFF);
      chk("regulator_en", regulator_en, 0);
      chk("core_reset_n", core_reset_n, 0);
      chk("clk_en", clk_en, exp_clk(M_STANDBY));
      wake_in.ext_lines = 16'($urandom) | 16'h0001;
      cyc(10);
      wake_in.ext_lines = 0;
      // flag is registered, so it shows one cycle after entry
      chk("standby_flag", standby_flag, 1);
      chk("mode", mode, M_STANDBY);
      wake_in[3-k] = ~wake_in[3-k];
      wait_mode(M_RESET);
      chk("regulator_en", regulator_en, 1);
      chk("standby_flag", standby_flag, 1);
      wake_in[3-k] = ~wake_in[3-k];
      wait_mode(M_RUN);
      chk("cpu_release", cpu_release, 1);
      check_bkp();
      chk("standby_flag", standby_flag, 0);
    end
    conclude();
  end
endmodule : testbench
